// [core/urx_pkg.sv]
// Constants and state type for the unblock receiver decision logic.
// Assumes a 50 MHz system clock and timers that count a 1 ms tick.
// How it works
// - Block present, no unblock: permission stays off
// - Block lost: permission on for 150 ms
// - Window expires: lockout, permission withdrawn
// - Unblock detected asserts permission directly
// - Unblock halts the channel-failure timer
// - No tones for 150 ms: lockout plus alarm
// - Unblock held 1000 ms: open breaker, allow trip
// - Send block; shift to unblock when keyed
// - Low power; boost while unblock keyed
package urx_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned CYCLES_PER_MS = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LOSS_WIN_MS   = 150;
  localparam int unsigned OPEN_BRK_MS   = 1000;
  localparam int unsigned LOSS_W        = 8;
  localparam int unsigned OPEN_W        = 10;
  localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(LOSS_WIN_MS - 1);
  localparam logic [OPEN_W-1:0] OPEN_LAST = OPEN_W'(OPEN_BRK_MS - 1);
  localparam logic [LOSS_W-1:0] LOSS_RST  = 8'h00;
  localparam logic [OPEN_W-1:0] OPEN_RST  = 10'h000;

  typedef enum logic [1:0] {
    ST_GUARD,
    ST_WINDOW,
    ST_LOCK
  } urx_state_t;
endpackage : urx_pkg

// [core/urx_tick_div.sv]
// Divider that makes a one-cycle enable pulse every millisecond.
// Assumes one system clock; the pulse is free running from reset.
`timescale 1ns/1ps
`default_nettype none
module urx_tick_div #(
  parameter int unsigned CYCLES = urx_pkg::CYCLES_PER_MS
) (
  input  wire logic clk,
  input  wire logic reset,
  urx_tick_if.src   tk
);
  import urx_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] DIV_LAST = CW'(CYCLES - 1);

  if (CYCLES < 2) begin : g_bad
    $error("urx_tick_div needs CYCLES of at least 2");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  always_comb begin
    next_tick = (cnt == DIV_LAST);
    next_cnt  = next_tick ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt     <= '0;
      tk.tick <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      tk.tick <= next_tick;
    end
  end
endmodule : urx_tick_div
`default_nettype wire

// [core/urx_tick_if.sv]
// Millisecond tick carried from the divider to the decision logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface urx_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : urx_tick_if
`default_nettype wire

// [core/urx_unblock_rx.sv]
// Unblock receiver decision logic and transmitter keying.
// Assumes tone detects, trip key and fault inputs arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module urx_unblock_rx #(
  parameter int unsigned CYCLES_PER_MS = urx_pkg::CYCLES_PER_MS
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic block_det,
  input  wire logic unblock_det,
  input  wire logic unblock_key,
  input  wire logic local_fault,
  output var  logic permission_relay,
  output var  logic lockout,
  output var  logic channel_alarm,
  output var  logic open_breaker,
  output var  logic breaker_trip,
  output var  logic tx_unblock,
  output var  logic tx_boost
);
  import urx_pkg::*;

  if (CYCLES_PER_MS < 2) begin : g_bad
    $error("urx_unblock_rx needs CYCLES_PER_MS of at least 2");
  end

  urx_tick_if tk ();

  urx_tick_div #(.CYCLES(CYCLES_PER_MS)) u_div (
    .clk   (clk),
    .reset (reset),
    .tk    (tk.src)
  );

  // Pins cross into the clock domain through two flops each
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // Block reads as present until the pins are seen: no false window
      sync1 <= 4'h1;
      sync2 <= 4'h1;
    end else begin
      sync1 <= {local_fault, unblock_key, unblock_det, block_det};
      sync2 <= sync1;
    end
  end

  logic block_s;
  logic unb_s;
  logic key_s;
  logic fault_s;
  assign block_s = sync2[0];
  assign unb_s   = sync2[1];
  assign key_s   = sync2[2];
  assign fault_s = sync2[3];

  urx_state_t        state;
  urx_state_t        next_state;
  logic [LOSS_W-1:0] loss_ms;
  logic [LOSS_W-1:0] next_loss_ms;
  logic [OPEN_W-1:0] open_ms;
  logic [OPEN_W-1:0] next_open_ms;
  logic              next_open_breaker;
  logic              next_alarm;
  logic              next_perm;

  always_comb begin
    next_state        = state;
    next_loss_ms      = LOSS_RST;
    next_open_ms      = open_ms;
    next_open_breaker = open_breaker;
    next_alarm        = channel_alarm;
    unique case (state)
      ST_GUARD: begin
        if (!block_s && !unb_s) begin
          next_state = ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        if (block_s || unb_s) begin
          next_state = ST_GUARD;
        end else if (tk.tick) begin
          if (loss_ms == LOSS_LAST) begin
            next_state = ST_LOCK;
            next_alarm = 1'b1;
          end else begin
            next_loss_ms = loss_ms + LOSS_W'(1);
          end
        end else begin
          next_loss_ms = loss_ms;
        end
      end
      ST_LOCK: begin
        if (block_s) begin
          next_state = ST_GUARD;
          next_alarm = 1'b0;
        end
      end
    endcase
    if (block_s) begin
      next_alarm = 1'b0;
    end
    if (!unb_s) begin
      next_open_ms      = OPEN_RST;
      next_open_breaker = 1'b0;
    end else if (tk.tick && !open_breaker) begin
      if (open_ms == OPEN_LAST) begin
        next_open_breaker = 1'b1;
      end else begin
        next_open_ms = open_ms + OPEN_W'(1);
      end
    end
    next_perm = unb_s || (next_state == ST_WINDOW);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state            <= ST_GUARD;
      loss_ms          <= LOSS_RST;
      open_ms          <= OPEN_RST;
      open_breaker     <= 1'b0;
      channel_alarm    <= 1'b0;
      permission_relay <= 1'b0;
      lockout          <= 1'b0;
      breaker_trip     <= 1'b0;
      tx_unblock       <= 1'b0;
      tx_boost         <= 1'b0;
    end else begin
      state            <= next_state;
      loss_ms          <= next_loss_ms;
      open_ms          <= next_open_ms;
      open_breaker     <= next_open_breaker;
      channel_alarm    <= next_alarm;
      permission_relay <= next_perm;
      lockout          <= (next_state == ST_LOCK);
      breaker_trip     <= next_open_breaker && fault_s;
      tx_unblock       <= key_s;
      tx_boost         <= key_s;
    end
  end

  // Checks: outputs lag the synchronised inputs by one edge
  chk_block_quiet: assert property (@(posedge clk) disable iff (reset)
    block_s && !unb_s |=> !permission_relay)
    else $error("permission while block held");
  chk_window_perm: assert property (@(posedge clk) disable iff (reset)
    state == ST_WINDOW |-> permission_relay && !lockout)
    else $error("window without permission");
  chk_lock_withdraw: assert property (@(posedge clk) disable iff (reset)
    state == ST_LOCK && !$past(unb_s) |-> !permission_relay && lockout)
    else $error("permission during lockout");
  chk_unblock_perm: assert property (@(posedge clk) disable iff (reset)
    unb_s |=> permission_relay)
    else $error("unblock without permission");
  chk_timer_halt: assert property (@(posedge clk) disable iff (reset)
    unb_s |=> loss_ms == LOSS_RST && state != ST_WINDOW)
    else $error("failure timer ran under unblock");
  chk_fail_alarm: assert property (@(posedge clk) disable iff (reset)
    state == ST_WINDOW && loss_ms == LOSS_LAST && tk.tick && !block_s && !unb_s
    |=> channel_alarm && lockout ##1 !permission_relay || $past(unb_s))
    else $error("no lockout after channel failure");
  chk_open_set: assert property (@(posedge clk) disable iff (reset)
    open_ms == OPEN_LAST && tk.tick && unb_s |=> open_breaker)
    else $error("open breaker not recognised");
  chk_open_early: assert property (@(posedge clk) disable iff (reset)
    $rose(open_breaker) |-> open_ms == OPEN_LAST && $past(unb_s))
    else $error("open breaker set early");
  chk_tx_shift: assert property (@(posedge clk) disable iff (reset)
    key_s |=> tx_unblock ##1 (tx_unblock == $past(key_s)))
    else $error("transmitter not shifted");
  chk_tx_boost: assert property (@(posedge clk) disable iff (reset)
    !key_s |=> !tx_boost && !tx_unblock)
    else $error("boost without unblock keying");
  chk_lock_hold: assert property (@(posedge clk) disable iff (reset)
    channel_alarm && !block_s |=> channel_alarm)
    else $error("alarm dropped without block");
  chk_tick_gap: assert property (@(posedge clk) disable iff (reset)
    tk.tick |=> !tk.tick)
    else $error("tick wider than one cycle");
  chk_reset_quiet: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> !permission_relay ##1 !permission_relay)
    else $error("permission right after reset");
  chk_window_start: assert property (@(posedge clk) disable iff (reset)
    state == ST_GUARD && !block_s && !unb_s |=> state == ST_WINDOW && permission_relay)
    else $error("loss of block did not open window");
  chk_lock_entry: assert property (@(posedge clk) disable iff (reset)
    state == ST_WINDOW && loss_ms == LOSS_LAST && tk.tick && !block_s && !unb_s
    |=> state == ST_LOCK && !permission_relay)
    else $error("window expiry without lockout");
  chk_trip_allow: assert property (@(posedge clk) disable iff (reset)
    open_breaker && unb_s && fault_s |=> breaker_trip)
    else $error("local trip not allowed on open breaker");
  chk_trip_gate: assert property (@(posedge clk) disable iff (reset)
    !fault_s |=> !breaker_trip)
    else $error("trip without local fault");
  chk_boost_track: assert property (@(posedge clk) disable iff (reset)
    key_s |=> tx_boost && tx_unblock)
    else $error("no boost while unblock keyed");
  chk_alarm_clear: assert property (@(posedge clk) disable iff (reset)
    block_s |=> !channel_alarm && !lockout)
    else $error("lockout kept after block returned");

  cov_window: cover property (@(posedge clk) disable iff (reset)
    state == ST_WINDOW ##1 state == ST_GUARD);
  cov_lockout: cover property (@(posedge clk) disable iff (reset)
    $rose(channel_alarm));
  cov_recover: cover property (@(posedge clk) disable iff (reset)
    state == ST_LOCK ##1 state == ST_GUARD);
  cov_open_brk: cover property (@(posedge clk) disable iff (reset)
    $rose(breaker_trip));
  cov_unblock_lock: cover property (@(posedge clk) disable iff (reset)
    state == ST_LOCK && permission_relay);
endmodule : urx_unblock_rx
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the unblock receiver with a remote model.
// Assumes a shortened ms tick of CPM cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CPM = 4;
  logic clk, reset, remote_key, channel_ok, unblock_key, local_fault;
  logic block_det, unblock_det, permission_relay, lockout, channel_alarm;
  logic open_breaker, breaker_trip, tx_unblock, tx_boost;
  int   n_mismatch, checks_done, cycles;
  typedef struct packed {logic rk; logic ok; logic lk; logic perm; logic tx;} urx_row_t;
  urx_row_t rows [4] = '{5'b01000, 5'b01101, 5'b11111, 5'b01000};

  urx_remote_model i_urx_remote_model (.clk(clk), .remote_key(remote_key),
    .channel_ok(channel_ok), .block_det(block_det), .unblock_det(unblock_det));
  urx_unblock_rx #(.CYCLES_PER_MS(CPM)) i_urx_unblock_rx (.clk(clk), .reset(reset),
    .block_det(block_det), .unblock_det(unblock_det), .unblock_key(unblock_key),
    .local_fault(local_fault), .permission_relay(permission_relay), .lockout(lockout),
    .channel_alarm(channel_alarm), .open_breaker(open_breaker),
    .breaker_trip(breaker_trip), .tx_unblock(tx_unblock), .tx_boost(tx_boost));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic drive(input logic rk, input logic ok, input logic lk, input logic lf);
    @(posedge clk);
    remote_key  <= rk;
    channel_ok  <= ok;
    unblock_key <= lk;
    local_fault <= lf;
  endtask : drive

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Ceiling well above the roughly 5000 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    n_mismatch = 0; checks_done = 0; cycles = 0;
    reset = 1'b1; remote_key = 1'b0; channel_ok = 1'b1;
    unblock_key = 1'b0; local_fault = 1'b0;
    settle(3);
    check(permission_relay, 1'b0);
    check(lockout, 1'b0);
    @(posedge clk);
    reset <= 1'b0;
    settle(2);
    check(permission_relay, 1'b0);
    check(channel_alarm, 1'b0);
    settle(2 * CPM);
    foreach (rows[i]) begin
      drive(rows[i].rk, rows[i].ok, rows[i].lk, 1'b0);
      settle(8);
      check(permission_relay, rows[i].perm);
      check(tx_unblock, rows[i].tx);
      check(tx_boost, rows[i].tx);
    end
    // Loss of block, then lockout and recovery
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    settle(8);
    check(permission_relay, 1'b1);
    settle(145 * CPM);
    check(permission_relay, 1'b1);
    check(lockout, 1'b0);
    settle(6 * CPM);
    check(lockout, 1'b1);
    check(channel_alarm, 1'b1);
    check(permission_relay, 1'b0);
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(8);
    check(permission_relay, 1'b1);
    check(lockout, 1'b1);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(8);
    check(lockout, 1'b0);
    check(channel_alarm, 1'b0);
    check(permission_relay, 1'b0);
    // Long unblock: no lockout, then open breaker
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    settle(990 * CPM);
    check(lockout, 1'b0);
    check(open_breaker, 1'b0);
    settle(12 * CPM);
    check(open_breaker, 1'b1);
    check(breaker_trip, 1'b0);
    drive(1'b1, 1'b1, 1'b0, 1'b1);
    settle(8);
    check(breaker_trip, 1'b1);
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    settle(8);
    check(open_breaker, 1'b0);
    check(breaker_trip, 1'b0);
    // Reset in mid-run while keyed
    drive(1'b1, 1'b1, 1'b1, 1'b0);
    reset <= 1'b1;
    settle(2);
    check(tx_unblock, 1'b0);
    check(permission_relay, 1'b0);
    @(posedge clk);
    reset <= 1'b0;
    settle(2);
    check(permission_relay, 1'b0);
    settle(2);
    check(permission_relay, 1'b1);
    check(tx_unblock, 1'b1);
    check(tx_boost, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// [sim/urx_remote_model.sv]
// Remote carrier terminal: turns its keying into tone detects.
// Assumes the bench steps remote_key and channel_ok on clk.
`timescale 1ns/1ps
`default_nettype none
module urx_remote_model (
  input  wire logic clk,
  input  wire logic remote_key,
  input  wire logic channel_ok,
  output var  logic block_det,
  output var  logic unblock_det
);
  // block unless keyed
  // A dead channel drops both tones, as a fault shorting the line does
  always @(posedge clk) begin
    block_det   <= channel_ok & ~remote_key;
    unblock_det <= channel_ok & remote_key;
  end
endmodule : urx_remote_model
`default_nettype wire
